// [core/usb_ep_cmd_defines.svh]
// command codes, status bit positions and sizes for the endpoint command block
`ifndef USB_EP_CMD_DEFINES_SVH
`define USB_EP_CMD_DEFINES_SVH

`define EP_COUNT 16
`define CMD_STALL_HI 4'h4
`define CMD_VALIDATE_HI 4'h6
`define CMD_CLEAR_HI 4'h7
`define CMD_UNSTALL_HI 4'h8
`define CMD_STATUS_COPY_HI 4'hD
`define CMD_STATUS_LIVE_HI 4'h5
`define CMD_ACK_SETUP 8'hF4
`define EP_CTRL_OUT 4'h0
`define EP_CTRL_IN 4'h1
`define STAT_STALLED 7
`define STAT_SEC_FULL 6
`define STAT_PRI_FULL 5
`define STAT_TOGGLE 4
`define STAT_OVERRUN 3
`define STAT_SETUP 2
`define STAT_BUF_SEL 1
`define STATUS_RESET 8'h00

`endif

// [core/usb_ep_cmd_pkg.sv]
// types shared by the endpoint command block
package usb_ep_cmd_pkg;
  typedef logic [3:0] ep_index_t;
  typedef logic [7:0] ep_status_t;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_STALL,
    OP_UNSTALL,
    OP_VALIDATE,
    OP_CLEAR,
    OP_READ_COPY,
    OP_READ_LIVE,
    OP_ACK_SETUP
  } cmd_op_t;
endpackage

// [core/usb_ep_cmd_decode.sv]
// command byte decoder: turns the command code into an operation and endpoint
`include "usb_ep_cmd_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module usb_ep_cmd_decode (
  // command byte
  input wire logic [7:0] code,
  // decoded operation
  output usb_ep_cmd_pkg::cmd_op_t op,
  output usb_ep_cmd_pkg::ep_index_t ep
);
  import usb_ep_cmd_pkg::*;

  wire [3:0] hi = code[7:4];
  wire isStall = (hi == `CMD_STALL_HI);
  wire isUnstall = (hi == `CMD_UNSTALL_HI);
  wire isValidate = (hi == `CMD_VALIDATE_HI) && (code[3:0] != `EP_CTRL_OUT);
  wire isClear = (hi == `CMD_CLEAR_HI) && (code[3:0] != `EP_CTRL_IN);
  wire isCopy = (hi == `CMD_STATUS_COPY_HI);
  wire isLive = (hi == `CMD_STATUS_LIVE_HI);
  wire isAck = (code == `CMD_ACK_SETUP);

  // priority chain of the recognised code groups
  assign op = isStall ? OP_STALL :
              isUnstall ? OP_UNSTALL :
              isValidate ? OP_VALIDATE :
              isClear ? OP_CLEAR :
              isCopy ? OP_READ_COPY :
              isLive ? OP_READ_LIVE :
              isAck ? OP_ACK_SETUP : OP_NONE;
  assign ep = code[3:0];
endmodule
`default_nettype wire

// [core/usb_ep_state.sv]
// per-endpoint state: stall, buffer full flags, toggle, setup and buffer select
`include "usb_ep_cmd_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module usb_ep_state #(
  parameter bit IS_IN = 1'b0,
  parameter bit IS_CTRL = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // configuration
  input wire logic doubleBuf,
  // processor commands
  input wire logic doStall,
  input wire logic doUnstall,
  input wire logic doRelease,
  input wire logic doReadLive,
  input wire logic doReadCopy,
  // serial engine events
  input wire logic setupToken,
  input wire logic setupDone,
  input wire logic pktDone,
  input wire logic pktToggle,
  // state out
  output usb_ep_cmd_pkg::ep_status_t status,
  output logic intFlag
);
  import usb_ep_cmd_pkg::*;

  logic stalled, priFull, secFull, toggle, overrun, setupHeld, bufSel, setupBusy;

  // a leaving stall reinitialises the endpoint
  wire leaveStall = stalled && (doUnstall || (IS_CTRL && setupToken));
  // with double buffering the engine-side buffer is the one the processor does not hold; single-buffered, both use the same one
  wire engSel = doubleBuf ? ~bufSel : bufSel;
  wire setPri = pktDone && !engSel;
  wire setSec = pktDone && engSel && doubleBuf;
  wire relPri = doRelease && !bufSel;
  wire relSec = doRelease && bufSel;
  wire newOverrun = IS_CTRL && setupToken && setupHeld;

  // stall flag and data toggle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stalled <= 1'b0;
      toggle <= 1'b0;
    end else begin
      if (doStall) begin
        stalled <= 1'b1;
      end else if (leaveStall) begin
        stalled <= 1'b0;
      end
      if (leaveStall) begin
        toggle <= 1'b0;
      end else if (pktDone) begin
        toggle <= ~pktToggle;
      end
    end
  end

  // buffer full flags and processor buffer select
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      priFull <= 1'b0;
      secFull <= 1'b0;
      bufSel <= 1'b0;
    end else if (leaveStall) begin
      priFull <= 1'b0;
      secFull <= 1'b0;
      bufSel <= 1'b0;
    end else begin
      priFull <= setPri || (priFull && !(IS_IN ? pktDone && !engSel : relPri)) || (IS_IN && relPri);
      secFull <= setSec || (secFull && !(IS_IN ? pktDone && engSel : relSec)) || (IS_IN && relSec);
      if (doRelease && doubleBuf) begin
        bufSel <= ~bufSel;
      end
    end
  end

  // setup presence, overrun and live-read interrupt flag
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      setupHeld <= 1'b0;
      setupBusy <= 1'b0;
      overrun <= 1'b0;
      intFlag <= 1'b0;
    end else begin
      if (IS_CTRL && setupToken) begin
        setupHeld <= 1'b1;
        setupBusy <= 1'b1;
      end else if (doStall || doRelease) begin
        setupHeld <= 1'b0;
      end
      if (setupDone) begin
        setupBusy <= 1'b0;
      end
      if (newOverrun) begin
        overrun <= 1'b1;
      end else if ((doReadCopy || doReadLive) && !setupBusy) begin
        overrun <= 1'b0;
      end
      if (pktDone || setupToken) begin
        intFlag <= 1'b1;
      end else if (doReadLive) begin
        intFlag <= 1'b0;
      end
    end
  end

  assign status = {stalled, secFull, priFull, toggle, overrun, setupHeld, bufSel, 1'b0};
endmodule
`default_nettype wire

// [core/usb_ep_cmd.sv]
// endpoint command interpreter of the device controller
// Contract
// - codes 40h-4Fh stall the addressed endpoint
// - codes 80h-8Fh unstall the addressed endpoint
// - setup token unstalls a stalled control endpoint
// - unstall flushes buffer and resets toggle DATA0
// - codes 61h-6Fh set IN buffer full (code sets full on endpoint 1 only; other IN endpoints are emptied)
// - validate or clear swaps double buffer select
// - codes 70h,72h-7Fh empty OUT endpoint buffer
// - received packet sets full, further packets NAK
// - D0h-DFh read status copy, clearing only overrun
// - copy bits: stall, full1, full0, toggle
// - bit2 setup present, bit1 buffer select
// - overrun set by overwriting setup, read clears
// - setup locks validate/clear until F4h
// - command on low byte with select high
// - live status read clears interrupt bit
`include "usb_ep_cmd_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module usb_ep_cmd #(
  parameter int EPS = `EP_COUNT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // processor parallel port
  input wire logic [15:0] dataIn,
  input wire logic command_data_select,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [15:0] dataOut,
  output logic dataOutEn,
  // endpoint configuration
  input wire logic [EPS-1:0] doubleBuffered,
  input wire logic [EPS-1:0] epIsIn,
  // serial engine side
  input wire logic setupToken,
  input wire logic setupDone,
  input wire logic pktDone,
  input wire usb_ep_cmd_pkg::ep_index_t pktEp,
  input wire logic pktToggle,
  output logic [EPS-1:0] epNak,
  output logic [EPS-1:0] epStalled,
  output logic [EPS-1:0] epInterrupt,
  output logic setupLocked
);
  import usb_ep_cmd_pkg::*;

  cmd_op_t op;
  ep_index_t ep;
  ep_status_t status [EPS];
  logic [EPS-1:0] intBits;
  logic pendRead;
  logic pendLive;
  ep_index_t pendEp;

  // command phase: low byte only, select line high
  wire cmdWrite = wrStrobe && command_data_select;

  usb_ep_cmd_decode decoder (
    .code(dataIn[7:0]),
    .op(op),
    .ep(ep)
  );

  // lock blocks validate/clear on both control endpoints
  wire ctrlEp = (ep == `EP_CTRL_OUT) || (ep == `EP_CTRL_IN);
  wire releaseOk = !(setupLocked && ctrlEp);
  wire readCopyNow = rdStrobe && !command_data_select && pendRead && !pendLive;
  wire readLiveNow = rdStrobe && !command_data_select && pendRead && pendLive;

  // one state block per endpoint
  genvar i;
  generate
    for (i = 0; i < EPS; i++) begin : g_ep
      wire hit = cmdWrite && (ep == i[3:0]);
      wire isIn = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : epIsIn[i];
      usb_ep_state #(
        .IS_IN(i == 1),
        .IS_CTRL(i < 2)
      ) st (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .doubleBuf(doubleBuffered[i] && (i >= 2)),
        .doStall(hit && op == OP_STALL),
        .doUnstall(hit && op == OP_UNSTALL),
        .doRelease(hit && releaseOk && (isIn ? op == OP_VALIDATE : op == OP_CLEAR)),
        .doReadLive(readLiveNow && pendEp == i[3:0]),
        .doReadCopy(readCopyNow && pendEp == i[3:0]),
        .setupToken(setupToken && i == 0),
        .setupDone(setupDone && i == 0),
        .pktDone(pktDone && pktEp == i[3:0] && !epNak[i]),
        .pktToggle(pktToggle),
        .status(status[i]),
        .intFlag(intBits[i])
      );
      // full OUT buffers refuse data; empty IN buffers have none
      assign epNak[i] = isIn ? !(status[i][`STAT_PRI_FULL] || status[i][`STAT_SEC_FULL])
                             : (status[i][`STAT_PRI_FULL] && (!(doubleBuffered[i] && (i >= 2)) || status[i][`STAT_SEC_FULL]));
      assign epStalled[i] = status[i][`STAT_STALLED];
    end
  endgenerate

  assign epInterrupt = intBits;
  assign dataOutEn = rdStrobe && !command_data_select;

  // setup lock and pending status read
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      setupLocked <= 1'b0;
      pendRead <= 1'b0;
      pendLive <= 1'b0;
      pendEp <= 4'h0;
    end else begin
      if (setupToken) begin
        setupLocked <= 1'b1;
      end else if (cmdWrite && op == OP_ACK_SETUP) begin
        setupLocked <= 1'b0;
      end
      if (cmdWrite) begin
        pendRead <= (op == OP_READ_COPY) || (op == OP_READ_LIVE);
        pendLive <= (op == OP_READ_LIVE);
        pendEp <= ep;
      end else if (rdStrobe && !command_data_select) begin
        pendRead <= 1'b0;
      end
    end
  end

  // read data register, status in the low byte
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dataOut <= {8'h00, `STATUS_RESET};
    end else if (cmdWrite && (op == OP_READ_COPY || op == OP_READ_LIVE)) begin
      dataOut <= {8'h00, status[ep]};
    end
  end

  // stall command sets the flag one cycle later
  a_stall_sets: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmdWrite && op == OP_STALL |=> epStalled[$past(ep)])
    else $error("stall command did not stall");
  // unstall clears stall and toggle
  a_unstall_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmdWrite && op == OP_UNSTALL && epStalled[ep] |=> !epStalled[$past(ep)] && !status[$past(ep)][`STAT_TOGGLE])
    else $error("unstall left stall or toggle set");
  // setup token unstalls control out
  a_setup_unstall: assert property (@(posedge clk_sys) disable iff (!rstn)
    setupToken && epStalled[0] && !(cmdWrite && op == OP_STALL && ep == 4'h0) |=> !epStalled[0])
    else $error("setup token did not unstall");
  // reinitialised endpoint has empty buffers
  a_reinit_flush: assert property (@(posedge clk_sys) disable iff (!rstn)
    epStalled[2] && cmdWrite && op == OP_UNSTALL && ep == 4'h2 |=> status[2][6:5] == 2'b00 && !status[2][`STAT_BUF_SEL])
    else $error("unstall did not flush");
  // setup token sets the lock one cycle later
  a_lock_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
    setupToken |=> setupLocked)
    else $error("setup did not lock");
  // locked validate leaves control in unchanged
  a_lock_no_change: assert property (@(posedge clk_sys) disable iff (!rstn)
    setupLocked && cmdWrite && op == OP_VALIDATE && ep == 4'h1 && !pktDone && !setupToken
      |=> status[1][6:1] == $past(status[1][6:1]))
    else $error("locked validate changed state");
  // copy read leaves interrupt bits alone
  a_copy_keeps_int: assert property (@(posedge clk_sys) disable iff (!rstn)
    readCopyNow |=> epInterrupt[$past(pendEp)] || !$past(epInterrupt[pendEp]))
    else $error("copy read cleared interrupt");
  // reserved bit always zero
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    dataOut[0] == 1'b0 && dataOut[15:8] == 8'h00)
    else $error("reserved bits nonzero");
endmodule
`default_nettype wire

// [verification/usb_ep_host_model.sv]
// processor model on the parallel command/data port
`timescale 1ns/10ps
`default_nettype none
module usb_ep_host_model #(
  parameter int GAP = 0
) (
  // clock
  input wire logic clk_sys,
  // parallel port
  output logic [15:0] dataIn,
  output logic command_data_select,
  output logic wrStrobe,
  output logic rdStrobe,
  input wire logic [15:0] dataOut,
  input wire logic dataOutEn
);
  // idle port at time zero
  initial begin
    dataIn = 16'h0000;
    command_data_select = 1'b1;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
  end

  // command phase, upper byte carries junk the block must ignore
  task automatic cmd(input logic [7:0] code);
    @(negedge clk_sys);
    dataIn <= {~code, code};
    command_data_select <= 1'b1;
    wrStrobe <= 1'b1;
    @(negedge clk_sys);
    wrStrobe <= 1'b0;
    dataIn <= ~dataIn;
    repeat (GAP) @(negedge clk_sys);
  endtask

  // data phase read of one word
  task automatic readWord(output logic [15:0] w, output logic en);
    @(negedge clk_sys);
    command_data_select <= 1'b0;
    rdStrobe <= 1'b1;
    @(posedge clk_sys);
    en = dataOutEn;
    @(negedge clk_sys);
    rdStrobe <= 1'b0;
    command_data_select <= 1'b1;
    w = dataOut;
  endtask

  // status command followed by its single data word
  task automatic readStatus(input logic [7:0] code, output logic [15:0] w, output logic en);
    cmd(code);
    readWord(w, en);
  endtask

  // acknowledge only when no overrun was flagged
  task automatic ackSetup(output logic ok);
    logic [15:0] w;
    logic en;
    readStatus(8'hD0, w, en);
    ok = (w[3] == 1'b0);
    if (ok) begin
      cmd(8'hF4);
    end
  endtask
endmodule
`default_nettype wire

// [verification/usb_ep_cmd_tb_top.sv]
// self-checking bench for the endpoint command block
`timescale 1ns/10ps
`default_nettype none
module usb_ep_cmd_tb_top;
  import usb_ep_cmd_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] dataIn, dataOut;
  logic command_data_select, wrStrobe, rdStrobe, dataOutEn, ok;
  logic [15:0] doubleBuffered = 16'h0008;
  logic [15:0] epIsIn = 16'h0008;
  logic setupToken = 1'b0;
  logic setupDone = 1'b0;
  logic pktDone = 1'b0;
  ep_index_t pktEp = 4'h0;
  logic pktToggle = 1'b0;
  logic [15:0] epNak, epStalled, epInterrupt, w;
  logic setupLocked;
  int miscompares = 0;
  int checksDone = 0;

  always #5 clk_sys = ~clk_sys;

  usb_ep_cmd u_usb_ep_cmd (.clk_sys(clk_sys), .rstn(rstn), .dataIn(dataIn),
    .command_data_select(command_data_select), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .dataOut(dataOut), .dataOutEn(dataOutEn), .doubleBuffered(doubleBuffered), .epIsIn(epIsIn),
    .setupToken(setupToken), .setupDone(setupDone), .pktDone(pktDone), .pktEp(pktEp),
    .pktToggle(pktToggle), .epNak(epNak), .epStalled(epStalled), .epInterrupt(epInterrupt),
    .setupLocked(setupLocked));
  usb_ep_host_model u_usb_ep_host_model (.clk_sys(clk_sys), .dataIn(dataIn),
    .command_data_select(command_data_select), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .dataOut(dataOut), .dataOutEn(dataOutEn));

  // comparison helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chkBit(input string what, input logic seen, input logic exp);
    check(what, {15'h0, seen}, {15'h0, exp});
  endtask
  task automatic settle;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic cmd(input logic [7:0] code);
    u_usb_ep_host_model.cmd(code);
    settle;
  endtask
  task automatic copyOf(input ep_index_t ep, output logic [15:0] v);
    logic en;
    u_usb_ep_host_model.readStatus({4'hD, ep}, v, en);
    chkBit("read enable", en, 1'b1);
  endtask
  // serial engine event: 0 setup token, 1 setup done, 2 packet
  task automatic pulseEvent(input int which, input ep_index_t ep, input logic tog);
    @(negedge clk_sys);
    pktEp <= ep;
    pktToggle <= tog;
    setupToken <= (which == 0);
    setupDone <= (which == 1);
    pktDone <= (which == 2);
    @(negedge clk_sys);
    {setupToken, setupDone, pktDone} <= 3'b000;
    settle;
  endtask

  // scenarios
  task automatic testReset;
    copyOf(4'h2, w);
    check("copy after reset", w, 16'h0000);
    check("nak after reset", epNak & 16'h000F, 16'h000A);
  endtask
  task automatic testStallAll;
    for (int i = 0; i < 16; i++) begin
      cmd({4'h4, i[3:0]});
      chkBit("stall flag", epStalled[i], 1'b1);
      copyOf(i[3:0], w);
      chkBit("copy stall bit", w[7], 1'b1);
      cmd({4'h8, i[3:0]});
      chkBit("unstall flag", epStalled[i], 1'b0);
    end
  endtask
  task automatic testSetupLock;
    cmd(8'h40);
    pulseEvent(0, 4'h0, 1'b0);
    chkBit("setup unstalls", epStalled[0], 1'b0);
    chkBit("setup lock", setupLocked, 1'b1);
    cmd(8'h61);
    chkBit("locked validate", epNak[1], 1'b1);
    u_usb_ep_host_model.ackSetup(ok);
    settle;
    chkBit("lock released", setupLocked, 1'b0);
    cmd(8'h61);
    chkBit("validate", epNak[1], 1'b0);
    copyOf(4'h1, w);
    chkBit("in full bit", w[5], 1'b1);
  endtask
  task automatic testOutPacket;
    logic en;
    pulseEvent(2, 4'h2, 1'b0);
    chkBit("out nak", epNak[2], 1'b1);
    pulseEvent(2, 4'h2, 1'b1);
    copyOf(4'h2, w);
    check("out status", w & 16'h00F0, 16'h0030);
    chkBit("interrupt kept", epInterrupt[2], 1'b1);
    u_usb_ep_host_model.readStatus(8'h52, w, en);
    chkBit("live read clears", epInterrupt[2], 1'b0);
    cmd(8'h72);
    chkBit("clear unlocks", epNak[2], 1'b0);
    pulseEvent(2, 4'h2, 1'b0);
    cmd(8'h42);
    cmd(8'h82);
    copyOf(4'h2, w);
    check("reinit", w & 16'h00F0, 16'h0000);
  endtask
  task automatic testDoubleBuf;
    cmd(8'h63);
    copyOf(4'h3, w);
    chkBit("buffer select", w[1], 1'b1);
  endtask
  task automatic testOverrun;
    pulseEvent(0, 4'h0, 1'b0);
    pulseEvent(0, 4'h0, 1'b0);
    copyOf(4'h0, w);
    check("overrun and setup", w & 16'h000C, 16'h000C);
    pulseEvent(1, 4'h0, 1'b0);
    copyOf(4'h0, w);
    copyOf(4'h0, w);
    chkBit("overrun cleared", w[3], 1'b0);
    u_usb_ep_host_model.ackSetup(ok);
    chkBit("ack issued", ok, 1'b1);
  endtask

  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(negedge clk_sys);
    rstn <= 1'b1;
    testReset;
    testStallAll;
    testSetupLock;
    testOutPacket;
    testDoubleBuf;
    testOverrun;
    complete_run;
  end

  // watchdog well beyond the expected few hundred cycles
  initial begin
    #200000;
    miscompares++;
    complete_run;
  end
endmodule
`default_nettype wire
